// ### rtl/ufs_pkg.sv
// Shared constants, types and helpers of the user flash sector store
package ufs_pkg;

    // Array geometry
    localparam int ADDR_W = 9;
    localparam int DATA_W = 16;
    localparam int SECT_W = 8;
    localparam logic [8:0] ADDR_LAST = 9'h1FF;
    localparam logic [8:0] SECT1_BASE = 9'h100;
    localparam logic [7:0] SECT_LAST = 8'hFF;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;

    // Serial frame layout
    localparam logic [4:0] CMD_BITS = 5'h03;
    localparam logic [4:0] ADDR_BITS = 5'h09;
    localparam logic [4:0] WORD_BITS = 5'h10;

    // Frame commands
    localparam logic [2:0] OP_READ = 3'h1;
    localparam logic [2:0] OP_READ_NEXT = 3'h2;
    localparam logic [2:0] OP_PROG = 3'h3;
    localparam logic [2:0] OP_PROG_NEXT = 3'h4;
    localparam logic [2:0] OP_ERASE = 3'h5;

    // Controller states, one-hot
    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_CMD = 8'h02,
        ST_ADDR = 8'h04,
        ST_DATA_IN = 8'h08,
        ST_PROG = 8'h10,
        ST_READ_WAIT = 8'h20,
        ST_DATA_OUT = 8'h40,
        ST_ERASE = 8'h80
    } ufs_state_t;

    // Whole controller state
    typedef struct packed {
        ufs_state_t state;
        logic [2:0] op;
        logic [4:0] cnt;
        logic [15:0] sh;
        logic [15:0] osh;
        logic [8:0] addr;
        logic [7:0] ecnt;
        logic sect;
        logic wait_rd;
        logic line_q;
        logic dout;
        logic busy;
    } ufs_regs_t;

    localparam ufs_regs_t REGS_RESET = '{
        state: ST_IDLE, op: 3'h0, cnt: 5'h00, sh: 16'h0000,
        osh: 16'h0000, addr: 9'h000, ecnt: 8'h00, sect: 1'b0,
        wait_rd: 1'b0, line_q: 1'b0, dout: 1'b0, busy: 1'b0};

    // Pull an n-bit field out of the input shifter for either bit order
    function automatic logic [15:0] ufs_field(input logic [15:0] sh,
                                              input logic [4:0] n,
                                              input logic lsb);
        logic [15:0] mask;
        mask = (16'h0001 << n) - 16'h0001;
        if (lsb)
            return sh >> (5'h10 - n);
        return (n == 5'h10) ? sh : (sh & mask);
    endfunction : ufs_field

endpackage : ufs_pkg

// ### rtl/ufs_mem.sv
// Word array of the user flash store with a registered read port
`timescale 1ns/10ps
`default_nettype none

module ufs_mem #(
    parameter int AW = ufs_pkg::ADDR_W,
    parameter int DW = ufs_pkg::DATA_W
) (
    // Clock
    input wire logic clk,
    // Write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    // Read port
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);

    logic [DW-1:0] mem [0:(1<<AW)-1];

    // No reset: contents are meant to survive a logic reset
    always_ff @(posedge clk) begin
        if (wr_en)
            mem[wr_addr] <= wr_data;
        rd_data <= mem[rd_addr];
    end

endmodule : ufs_mem
`default_nettype wire

// ### rtl/ufs_sector_store.sv
// Serial-access user flash sector store with sector erase
//
// Overview of operation
// - Store holds 8192 bits in two sectors of 4096 bits.
// - 512 word locations addressed by 9 bits, 000h to 1FFh.
// - Sector 0 is 000h-0FFh, sector 1 is 100h-1FFh.
// - Each location holds a 16-bit word.
// - Erase clears one whole sector; full clear takes two erases.
// - Erasing one sector leaves the other sector untouched.
// - Serial link to the fabric with user-selectable framing.
// - Shift clock chosen from any of the four global lines.
`timescale 1ns/10ps
`default_nettype none

module ufs_sector_store (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // Shift clock selection
    input wire logic [3:0] GLOBAL_CLOCK_LINES,
    input wire logic [1:0] CLK_SEL,
    // Serial link
    input wire logic SER_SEL,
    input wire logic SER_DI,
    input wire logic LSB_FIRST,
    output logic SER_DO,
    // Status
    output logic BUSY
);

    ufs_pkg::ufs_regs_t st;
    ufs_pkg::ufs_regs_t next_st;
    logic line_now;
    logic shift_edge;
    logic [15:0] sh_in;
    logic [15:0] fld;
    logic [15:0] rd_data;
    logic wr_en;
    logic [8:0] wr_addr;
    logic [15:0] wr_data;

    // Shift clock taken from the chosen global line
    assign line_now = GLOBAL_CLOCK_LINES[CLK_SEL];
    assign shift_edge = line_now & ~st.line_q;
    // Bit order is a framing choice of the user design
    assign sh_in = LSB_FIRST ? {SER_DI, st.sh[15:1]}
                             : {st.sh[14:0], SER_DI};

    // Array writes: erase sweeps one sector, program writes one word
    always_comb begin
        wr_en = 1'b0;
        wr_addr = st.addr;
        wr_data = st.sh;
        if (st.state == ufs_pkg::ST_ERASE) begin
            wr_en = 1'b1;
            wr_addr = {st.sect, st.ecnt};
            wr_data = ufs_pkg::ERASED_WORD;
        end else if (st.state == ufs_pkg::ST_PROG) begin
            wr_en = 1'b1;
        end
    end

    ufs_mem #(
        .AW(ufs_pkg::ADDR_W),
        .DW(ufs_pkg::DATA_W)
    ) u_mem (
        .clk(CLK),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .rd_addr(st.addr),
        .rd_data(rd_data)
    );

    // Frame decoder and sequencer
    always_comb begin
        next_st = st;
        fld = 16'h0000;
        next_st.line_q = line_now;
        case (st.state)
            ufs_pkg::ST_IDLE: begin
                // A refused command parks here until the frame closes
                if (SER_SEL && !st.wait_rd) begin
                    next_st.state = ufs_pkg::ST_CMD;
                    next_st.cnt = 5'h00;
                end
            end
            ufs_pkg::ST_CMD: begin
                if (shift_edge) begin
                    next_st.sh = sh_in;
                    next_st.cnt = st.cnt + 5'h01;
                    if (st.cnt == ufs_pkg::CMD_BITS - 5'h01) begin
                        fld = ufs_pkg::ufs_field(sh_in, ufs_pkg::CMD_BITS,
                                                 LSB_FIRST);
                        next_st.op = fld[2:0];
                        next_st.cnt = 5'h00;
                        next_st.wait_rd = 1'b0;
                        case (fld[2:0])
                            ufs_pkg::OP_READ,
                            ufs_pkg::OP_PROG,
                            ufs_pkg::OP_ERASE:
                                next_st.state = ufs_pkg::ST_ADDR;
                            // Continue at the current pointer
                            ufs_pkg::OP_READ_NEXT:
                                next_st.state = ufs_pkg::ST_READ_WAIT;
                            ufs_pkg::OP_PROG_NEXT:
                                next_st.state = ufs_pkg::ST_DATA_IN;
                            // Unknown command: ignore rest of frame
                            default: begin
                                next_st.state = ufs_pkg::ST_IDLE;
                                next_st.wait_rd = 1'b1;
                            end
                        endcase
                    end
                end
            end
            ufs_pkg::ST_ADDR: begin
                if (shift_edge) begin
                    next_st.sh = sh_in;
                    next_st.cnt = st.cnt + 5'h01;
                    if (st.cnt == ufs_pkg::ADDR_BITS - 5'h01) begin
                        fld = ufs_pkg::ufs_field(sh_in, ufs_pkg::ADDR_BITS,
                                                 LSB_FIRST);
                        next_st.addr = fld[8:0];
                        next_st.cnt = 5'h00;
                        if (st.op == ufs_pkg::OP_ERASE) begin
                            // Address bit 8 names the sector
                            next_st.sect = fld[8];
                            next_st.ecnt = 8'h00;
                            next_st.busy = 1'b1;
                            next_st.state = ufs_pkg::ST_ERASE;
                        end else if (st.op == ufs_pkg::OP_READ) begin
                            next_st.state = ufs_pkg::ST_READ_WAIT;
                        end else begin
                            next_st.state = ufs_pkg::ST_DATA_IN;
                        end
                    end
                end
            end
            ufs_pkg::ST_DATA_IN: begin
                if (shift_edge) begin
                    next_st.sh = sh_in;
                    next_st.cnt = st.cnt + 5'h01;
                    if (st.cnt == ufs_pkg::WORD_BITS - 5'h01)
                        next_st.state = ufs_pkg::ST_PROG;
                end
            end
            ufs_pkg::ST_PROG: begin
                // Word written this cycle; pointer moves on for streaming
                next_st.addr = st.addr + 9'h001;
                next_st.cnt = 5'h00;
                next_st.state = ufs_pkg::ST_DATA_IN;
            end
            ufs_pkg::ST_READ_WAIT: begin
                // One cycle for the array's registered read port
                if (!st.wait_rd) begin
                    next_st.wait_rd = 1'b1;
                end else begin
                    next_st.wait_rd = 1'b0;
                    next_st.osh = rd_data;
                    next_st.dout = LSB_FIRST ? rd_data[0] : rd_data[15];
                    next_st.addr = st.addr + 9'h001;
                    next_st.cnt = 5'h00;
                    next_st.state = ufs_pkg::ST_DATA_OUT;
                end
            end
            ufs_pkg::ST_DATA_OUT: begin
                if (shift_edge) begin
                    next_st.osh = LSB_FIRST ? {1'b0, st.osh[15:1]}
                                            : {st.osh[14:0], 1'b0};
                    next_st.dout = LSB_FIRST ? st.osh[1] : st.osh[14];
                    next_st.cnt = st.cnt + 5'h01;
                    // Stream the next word without a new address
                    if (st.cnt == ufs_pkg::WORD_BITS - 5'h01)
                        next_st.state = ufs_pkg::ST_READ_WAIT;
                end
            end
            ufs_pkg::ST_ERASE: begin
                // Sweep runs to the end even if the frame closes
                next_st.ecnt = st.ecnt + 8'h01;
                if (st.ecnt == ufs_pkg::SECT_LAST) begin
                    next_st.busy = 1'b0;
                    next_st.state = ufs_pkg::ST_IDLE;
                end
            end
            default: next_st = ufs_pkg::REGS_RESET;
        endcase
        // Frame end aborts any access except a running erase
        if (!SER_SEL && st.state != ufs_pkg::ST_ERASE) begin
            next_st.state = ufs_pkg::ST_IDLE;
            next_st.wait_rd = 1'b0;
        end
    end

    // State register
    always_ff @(posedge CLK) begin
        if (!RST_B)
            st <= ufs_pkg::REGS_RESET;
        else
            st <= next_st;
    end

    assign SER_DO = st.dout;
    assign BUSY = st.busy;

    // Checks
    property p_erase_sector;
        @(posedge CLK) disable iff (!RST_B)
        st.state == ufs_pkg::ST_ERASE |-> wr_en && wr_addr[8] == st.addr[8];
    endproperty
    a_erase_sector: assert property (p_erase_sector)
        else $error("erase write left its sector");

    property p_erase_ones;
        @(posedge CLK) disable iff (!RST_B)
        st.state == ufs_pkg::ST_ERASE |-> wr_data == 16'hFFFF;
    endproperty
    a_erase_ones: assert property (p_erase_ones)
        else $error("erase wrote a word other than all ones");

    property p_erase_start;
        @(posedge CLK) disable iff (!RST_B)
        $rose(st.state == ufs_pkg::ST_ERASE) |->
            wr_addr[7:0] == 8'h00 && BUSY;
    endproperty
    a_erase_start: assert property (p_erase_start)
        else $error("erase did not start at sector base");

    property p_erase_holds;
        @(posedge CLK) disable iff (!RST_B)
        st.state == ufs_pkg::ST_ERASE && st.ecnt != 8'hFF |=>
            st.state == ufs_pkg::ST_ERASE &&
            st.ecnt == $past(st.ecnt) + 8'h01;
    endproperty
    a_erase_holds: assert property (p_erase_holds)
        else $error("erase sweep cut short");

    property p_erase_ends;
        @(posedge CLK) disable iff (!RST_B)
        st.state == ufs_pkg::ST_ERASE && st.ecnt == 8'hFF |=>
            st.state != ufs_pkg::ST_ERASE && !BUSY;
    endproperty
    a_erase_ends: assert property (p_erase_ends)
        else $error("erase ran past 256 words");

    property p_prog_inc;
        @(posedge CLK) disable iff (!RST_B)
        st.state == ufs_pkg::ST_PROG |=>
            st.addr == $past(st.addr) + 9'h001;
    endproperty
    a_prog_inc: assert property (p_prog_inc)
        else $error("pointer did not advance after program");

    property p_read_inc;
        @(posedge CLK) disable iff (!RST_B)
        st.state == ufs_pkg::ST_READ_WAIT && st.wait_rd && SER_SEL |=>
            st.state == ufs_pkg::ST_DATA_OUT &&
            st.addr == $past(st.addr) + 9'h001;
    endproperty
    a_read_inc: assert property (p_read_inc)
        else $error("pointer did not advance after read");

    property p_frame_end;
        @(posedge CLK) disable iff (!RST_B)
        !SER_SEL && st.state != ufs_pkg::ST_ERASE |=>
            st.state == ufs_pkg::ST_IDLE;
    endproperty
    a_frame_end: assert property (p_frame_end)
        else $error("frame end did not return to idle");

    property p_out_on_edge;
        @(posedge CLK) disable iff (!RST_B)
        st.state == ufs_pkg::ST_DATA_OUT &&
            $past(st.state == ufs_pkg::ST_DATA_OUT) && $changed(SER_DO)
            |-> $past(shift_edge);
    endproperty
    a_out_on_edge: assert property (p_out_on_edge)
        else $error("output bit moved without a shift edge");

    c_erase: cover property (@(posedge CLK) disable iff (!RST_B)
        st.state == ufs_pkg::ST_ERASE && st.ecnt == 8'hFF);
    c_prog: cover property (@(posedge CLK) disable iff (!RST_B)
        st.state == ufs_pkg::ST_PROG);
    c_read: cover property (@(posedge CLK) disable iff (!RST_B)
        st.state == ufs_pkg::ST_DATA_OUT && shift_edge);
    c_stream: cover property (@(posedge CLK) disable iff (!RST_B)
        st.state == ufs_pkg::ST_READ_WAIT &&
        $past(st.state == ufs_pkg::ST_DATA_OUT));

endmodule : ufs_sector_store
`default_nettype wire

// ### verification/ufs_fabric_model.sv
// Fabric-side user logic model that drives the serial link of the store
`timescale 1ns/10ps
`default_nettype none

module ufs_fabric_model (
    // Clock and framing option
    input wire logic clk,
    input wire logic [1:0] sel,
    input wire logic lsb,
    // Serial link
    output logic [3:0] glines,
    output logic ser_sel,
    output logic ser_di,
    input wire logic ser_do
);
    logic ln = 1'b0;
    logic [3:0] noise = 4'h0;

    // Quiet link at time zero
    initial begin
        ser_sel = 1'b0;
        ser_di = 1'b0;
    end

    // Unselected lines toggle, so a wrong line pick shows at once
    always @(negedge clk) noise <= ~noise;

    // Selected line carries the shift clock, low outside frames
    always_comb begin
        glines = noise;
        glines[sel] = ln;
    end

    // One shift period of four cycles; data held across the edge
    task automatic shift(input logic b, output logic q);
        @(negedge clk);
        ln = 1'b0;
        ser_di = b;
        @(negedge clk);
        @(negedge clk);
        q = ser_do;
        ln = 1'b1;
        @(negedge clk);
    endtask : shift

    // Field of n bits in the chosen bit order
    task automatic send(input logic [15:0] v, input int n);
        logic q;
        for (int i = 0; i < n; i++)
            shift(lsb ? v[i] : v[n - 1 - i], q);
    endtask : send

    // One data word; data input keeps changing as it is unused
    task automatic recv(output logic [15:0] w);
        logic q;
        for (int i = 0; i < 16; i++) begin
            shift(~ser_di, q);
            if (lsb)
                w[i] = q;
            else
                w[15 - i] = q;
        end
    endtask : recv

    // Frame select, then the command field
    task automatic open_frame(input logic [2:0] op);
        @(negedge clk);
        ser_sel = 1'b1;
        send({13'h0000, op}, 3);
    endtask : open_frame

    // Released data line shows the inverse, not a stale value
    task automatic release_link();
        ln = 1'b0;
        ser_sel = 1'b0;
        ser_di = ~ser_di;
    endtask : release_link

    // End a frame and leave a short idle gap
    task automatic close_frame();
        @(negedge clk);
        release_link();
        repeat (3) @(negedge clk);
    endtask : close_frame

endmodule : ufs_fabric_model
`default_nettype wire

// ### verification/ufs_sector_store_tb.sv
// Self-checking testbench of the user flash sector store
`timescale 1ns/10ps
`default_nettype none

module ufs_sector_store_tb;
    logic clk;
    logic rst_b = 1'b0;
    logic [1:0] clk_sel = 2'h0;
    logic lsb_first = 1'b0;
    logic [3:0] glines;
    logic ser_sel;
    logic ser_di;
    logic ser_do;
    logic busy;
    int n_mismatch = 0;
    int checks_done = 0;

    // Design and fabric-side partner
    ufs_sector_store uut (
        .CLK(clk), .RST_B(rst_b), .GLOBAL_CLOCK_LINES(glines),
        .CLK_SEL(clk_sel), .SER_SEL(ser_sel), .SER_DI(ser_di),
        .LSB_FIRST(lsb_first), .SER_DO(ser_do), .BUSY(busy));
    ufs_fabric_model fab (
        .clk(clk), .sel(clk_sel), .lsb(lsb_first), .glines(glines),
        .ser_sel(ser_sel), .ser_di(ser_di), .ser_do(ser_do));

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word

    // Program n words d, d+1, ...; PROG_NEXT uses the pointer
    task automatic wr(input logic [2:0] op, input logic [8:0] a,
                      input logic [15:0] d, input int n);
        fab.open_frame(op);
        if (op == ufs_pkg::OP_PROG)
            fab.send({7'h00, a}, 9);
        for (int i = 0; i < n; i++)
            fab.send(d + 16'(i), 16);
        fab.close_frame();
    endtask : wr

    // Stream n words and expect e, e+step, ...
    task automatic rd(input logic [2:0] op, input logic [8:0] a,
                      input logic [15:0] e, input logic [15:0] step,
                      input int n);
        logic [15:0] w;
        fab.open_frame(op);
        if (op == ufs_pkg::OP_READ)
            fab.send({7'h00, a}, 9);
        for (int i = 0; i < n; i++) begin
            fab.recv(w);
            chk_word(w, e + step * 16'(i));
        end
        fab.close_frame();
    endtask : rd

    // Sector erase; busy must stand exactly one sweep of 256 cycles
    task automatic erase(input logic s);
        int c;
        c = 0;
        fab.open_frame(ufs_pkg::OP_ERASE);
        fab.send({7'h00, s, 8'hA5}, 9);
        // Released right after the last address edge: first busy cycle counts
        fab.release_link();
        while (busy === 1'b1 && c < 300) begin
            c++;
            @(negedge clk);
        end
        chk_word(16'(c), 16'h0100);
        repeat (2) @(negedge clk);
    endtask : erase

    // Both sectors wiped by two erases, read back all ones
    task automatic t_erase_all();
        erase(1'b0);
        erase(1'b1);
        rd(ufs_pkg::OP_READ, 9'h000, 16'hFFFF, 16'h0000, 2);
        rd(ufs_pkg::OP_READ, 9'h0FF, 16'hFFFF, 16'h0000, 2);
        rd(ufs_pkg::OP_READ, 9'h1FF, 16'hFFFF, 16'h0000, 2);
    endtask : t_erase_all

    // Streams across the sector border and the top address
    task automatic t_stream();
        wr(ufs_pkg::OP_PROG, 9'h0FE, 16'h1230, 4);
        wr(ufs_pkg::OP_PROG_NEXT, 9'h000, 16'h1234, 1);
        rd(ufs_pkg::OP_READ, 9'h0FE, 16'h1230, 16'h0001, 5);
        wr(ufs_pkg::OP_PROG, 9'h1FF, 16'hA5A5, 1);
        wr(ufs_pkg::OP_PROG_NEXT, 9'h000, 16'hA5A6, 1);
        rd(ufs_pkg::OP_READ, 9'h1FF, 16'hA5A5, 16'h0001, 2);
    endtask : t_stream

    // Wiping sector 0 leaves sector 1 intact
    task automatic t_keep_other();
        erase(1'b0);
        rd(ufs_pkg::OP_READ, 9'h000, 16'hFFFF, 16'h0000, 1);
        rd(ufs_pkg::OP_READ, 9'h0FF, 16'hFFFF, 16'h0000, 1);
        rd(ufs_pkg::OP_READ, 9'h100, 16'h1232, 16'h0001, 3);
        rd(ufs_pkg::OP_READ, 9'h1FF, 16'hA5A5, 16'h0000, 1);
    endtask : t_keep_other

    // Bit order option: written LSB first, read in both orders
    task automatic t_framing();
        lsb_first = 1'b1;
        wr(ufs_pkg::OP_PROG, 9'h013, 16'h8001, 2);
        rd(ufs_pkg::OP_READ_NEXT, 9'h000, 16'hFFFF, 16'h0000, 1);
        lsb_first = 1'b0;
        rd(ufs_pkg::OP_READ, 9'h013, 16'h8001, 16'h0001, 2);
        lsb_first = 1'b1;
        rd(ufs_pkg::OP_READ, 9'h013, 16'h8001, 16'h0001, 2);
        lsb_first = 1'b0;
    endtask : t_framing

    // Refused command and a cut word leave the array alone
    task automatic t_refuse();
        fab.open_frame(3'h6);
        fab.send(16'h0003, 3);
        fab.send(16'h0013, 9);
        fab.send(16'h0000, 16);
        fab.close_frame();
        fab.open_frame(ufs_pkg::OP_PROG);
        fab.send(16'h0014, 9);
        fab.send(16'h0000, 8);
        fab.close_frame();
        rd(ufs_pkg::OP_READ, 9'h013, 16'h8001, 16'h0001, 2);
    endtask : t_refuse

    // Every global line serves as shift clock in turn
    task automatic t_lines();
        for (int s = 3; s >= 0; s--) begin
            @(negedge clk);
            clk_sel = 2'(s);
            wr(ufs_pkg::OP_PROG, 9'h020 + 9'(s), 16'hC3C0 + 16'(s), 1);
            rd(ufs_pkg::OP_READ, 9'h020 + 9'(s), 16'hC3C0 + 16'(s),
               16'h0000, 1);
        end
    endtask : t_lines

    // Hang guard, well beyond the few thousand cycles needed
    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        results();
    end

    // Main sequence
    initial begin
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        t_erase_all();
        t_stream();
        t_keep_other();
        t_framing();
        t_refuse();
        t_lines();
        results();
    end

endmodule : ufs_sector_store_tb
`default_nettype wire
